// file: rtl/lsd_pkg.sv
// ============================================================
// Constants for the per-channel LVDS sync delay and HSync width
package lsd_pkg;

  // ============================================================
  // Widths and queue depth
  localparam int unsigned LSD_DLY_W = 12;
  localparam int unsigned LSD_WID_W = 10;
  localparam int unsigned LSD_TS_W = 13;
  localparam int unsigned LSD_ADDR_W = 12;
  localparam int unsigned LSD_QDEPTH = 4;

  // ============================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] LSD_IDX_MODE = 8'h10;
  localparam logic [7:0] LSD_IDX_LINK = 8'h18;
  localparam logic [7:0] LSD_IDX_CHA_DLY_LO = 8'h28;
  localparam logic [7:0] LSD_IDX_CHA_DLY_HI = 8'h29;
  localparam logic [7:0] LSD_IDX_CHB_DLY_LO = 8'h2A;
  localparam logic [7:0] LSD_IDX_CHB_DLY_HI = 8'h2B;
  localparam logic [7:0] LSD_IDX_CHA_WID_LO = 8'h2C;
  localparam logic [7:0] LSD_IDX_CHA_WID_HI = 8'h2D;
  localparam logic [7:0] LSD_IDX_CHB_WID_LO = 8'h2E;
  localparam logic [7:0] LSD_IDX_CHB_WID_HI = 8'h2F;
  localparam logic [7:0] LSD_IDX_STATUS = 8'h40;

  // ============================================================
  // Field positions and encodings
  localparam int unsigned LSD_LINK_SINGLE_BIT = 4;
  localparam int unsigned LSD_MODE_LSB = 5;
  localparam logic [1:0] LSD_MODE_TWO_STREAM = 2'h2;
  localparam int unsigned LSD_ST_OVF_A_BIT = 4;
  localparam int unsigned LSD_ST_OVF_B_BIT = 5;

  // ============================================================
  // Reset values and cycle counts
  localparam logic [7:0] LSD_RST_BYTE = 8'h00;
  localparam logic [LSD_TS_W-1:0] LSD_FIXED_LAT = 13'h00A;
  localparam logic [LSD_TS_W-1:0] LSD_FIXED_ADJ = LSD_FIXED_LAT - 13'h001;

  function automatic logic [LSD_ADDR_W-1:0] lsd_byte_addr(input logic [7:0] idx);
    lsd_byte_addr = {2'h0, idx, 2'h0};
  endfunction : lsd_byte_addr

endpackage : lsd_pkg

// file: rtl/lsd_sync_chan.sv
`timescale 1ns/1ps
// ============================================================
// One LVDS channel: timestamp queues for HSync and VSync, HSync stretcher
module lsd_sync_chan
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hs_in,
  input wire logic vs_in,
  input wire logic [lsd_pkg::LSD_DLY_W-1:0] delay,
  input wire logic [lsd_pkg::LSD_WID_W-1:0] width,
  output logic hs_out,
  output logic vs_out,
  output logic ovf
);
  import lsd_pkg::*;

  logic [LSD_TS_W-1:0] now;
  logic [1:0] fire;
  logic [1:0] drop;
  logic [LSD_WID_W-1:0] hs_cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      now <= '0;
    else
      now <= now + 13'h001;
  end

  // Queue of due times lets several syncs be in flight when the delay spans lines
  for (genvar k = 0; k < 2; k++)
  begin : g_q
    logic [LSD_TS_W-1:0] q [LSD_QDEPTH];
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] cnt;
    logic ev;
    logic pop;
    logic push;
    assign ev = (k == 0) ? hs_in : vs_in;
    assign pop = (cnt != 3'h0) && (q[rp] == now);
    assign push = ev && ((cnt != 3'(LSD_QDEPTH)) || pop);
    assign fire[k] = pop;
    assign drop[k] = ev && !push;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        wp <= '0;
        rp <= '0;
        cnt <= '0;
        for (int i = 0; i < LSD_QDEPTH; i++)
          q[i] <= '0;
      end
      else
      begin
        if (push)
        begin
          q[wp] <= now + {1'b0, delay} + LSD_FIXED_ADJ;
          wp <= wp + 2'h1;
        end
        if (pop)
          rp <= rp + 2'h1;
        cnt <= cnt + {2'h0, push} - {2'h0, pop};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs_cnt <= '0;
      hs_out <= 1'b0;
      vs_out <= 1'b0;
      ovf <= 1'b0;
    end
    else
    begin
      vs_out <= fire[1];
      ovf <= |drop;
      if (fire[0])
      begin
        hs_cnt <= width;
        hs_out <= (width != '0);
      end
      else
      begin
        if (hs_cnt != '0)
          hs_cnt <= hs_cnt - 10'h001;
        hs_out <= (hs_cnt > 10'h001);
      end
    end
  end

  // ============================================================
  // Checks
  logic [LSD_TS_W-1:0] meas;
  logic track;
  logic [LSD_WID_W-1:0] hs_len;
  logic [LSD_WID_W-1:0] hs_last_w;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meas <= '0;
      track <= 1'b0;
      hs_len <= '0;
      hs_last_w <= '0;
    end
    else
    begin
      if (vs_in && g_q[1].cnt == 3'h0)
      begin
        track <= 1'b1;
        meas <= 13'h001;
      end
      else if (vs_out)
        track <= 1'b0;
      else
        meas <= meas + 13'h001;
      if (fire[0])
      begin
        hs_len <= '0;
        hs_last_w <= width;
      end
      else if (hs_out)
        hs_len <= hs_len + 10'h001;
    end
  end

  a_vsync_latency: assert property (@(posedge pclk) disable iff (!presetn)
    (vs_out && track && $stable(delay)) |-> (meas == {1'b0, delay} + LSD_FIXED_LAT))
    else $error("vsync latency differs from delay plus fixed part");

  a_hsync_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(hs_out) |-> (hs_len == hs_last_w))
    else $error("hsync pulse length differs from programmed width");

endmodule : lsd_sync_chan

// file: rtl/lsd_top.sv
`timescale 1ns/1ps
// ============================================================
// LVDS output sync delay and HSync width, APB slave

module lsd_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lsd_pkg::LSD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dsi_hsync_a,
  input wire logic dsi_vsync_a,
  input wire logic dsi_hsync_b,
  input wire logic dsi_vsync_b,
  output logic lvds_hsync_a,
  output logic lvds_vsync_a,
  output logic lvds_hsync_b,
  output logic lvds_vsync_b
);
  import lsd_pkg::*;

  // ============================================================
  // Register storage
  logic [7:0] mode_reg;
  logic [7:0] link_reg;
  logic [7:0] first_channel_delay_low_byte;
  logic [3:0] first_channel_delay_high_nibble;
  logic [7:0] second_channel_delay_low_byte;
  logic [3:0] second_channel_delay_high_nibble;
  logic [7:0] first_channel_hwidth_low_byte;
  logic [1:0] first_channel_hwidth_high_bits;
  logic [7:0] second_channel_hwidth_low_byte;
  logic [1:0] second_channel_hwidth_high_bits;
  logic ovf_a;
  logic ovf_b;

  // ============================================================
  // Bus decode
  logic setup_ph;
  logic wr_acc;
  logic idx_hit;
  logic [31:0] next_rdata;

  assign setup_ph = psel && !penable && !pready;
  assign wr_acc = psel && penable && pready && pwrite && !pslverr;

  function automatic logic mapped(input logic [LSD_ADDR_W-1:0] a);
    logic [LSD_ADDR_W-1:0] b;
    b = {a[LSD_ADDR_W-1:2], 2'h0};
    mapped = (b == lsd_byte_addr(LSD_IDX_MODE)) || (b == lsd_byte_addr(LSD_IDX_LINK))
      || (b == lsd_byte_addr(LSD_IDX_CHA_DLY_LO)) || (b == lsd_byte_addr(LSD_IDX_CHA_DLY_HI))
      || (b == lsd_byte_addr(LSD_IDX_CHB_DLY_LO)) || (b == lsd_byte_addr(LSD_IDX_CHB_DLY_HI))
      || (b == lsd_byte_addr(LSD_IDX_CHA_WID_LO)) || (b == lsd_byte_addr(LSD_IDX_CHA_WID_HI))
      || (b == lsd_byte_addr(LSD_IDX_CHB_WID_LO)) || (b == lsd_byte_addr(LSD_IDX_CHB_WID_HI))
      || (b == lsd_byte_addr(LSD_IDX_STATUS));
  endfunction : mapped

  function automatic logic hit(input logic [LSD_ADDR_W-1:0] a, input logic [7:0] i);
    hit = ({a[LSD_ADDR_W-1:2], 2'h0} == lsd_byte_addr(i));
  endfunction : hit

  assign idx_hit = mapped(paddr);

  // ============================================================
  // Mode decode
  logic single_link;
  logic two_stream;
  logic [LSD_DLY_W-1:0] dly_a;
  logic [LSD_DLY_W-1:0] dly_b_prog;
  logic [LSD_WID_W-1:0] wid_a;
  logic [LSD_WID_W-1:0] wid_b_prog;
  logic [LSD_DLY_W-1:0] dly_b;
  logic [LSD_WID_W-1:0] wid_b;
  logic ev_hs_b;
  logic ev_vs_b;
  logic ch_hs_a;
  logic ch_vs_a;
  logic ch_ovf_a;
  logic ch_hs_b;
  logic ch_vs_b;
  logic ch_ovf_b;

  assign single_link = link_reg[LSD_LINK_SINGLE_BIT];
  // Reserved mode 11 falls back to shared channel A timing
  assign two_stream = !single_link && (mode_reg[LSD_MODE_LSB+:2] == LSD_MODE_TWO_STREAM);

  assign dly_a = {first_channel_delay_high_nibble, first_channel_delay_low_byte};
  assign dly_b_prog = {second_channel_delay_high_nibble, second_channel_delay_low_byte};
  assign wid_a = {first_channel_hwidth_high_bits, first_channel_hwidth_low_byte};
  assign wid_b_prog = {second_channel_hwidth_high_bits, second_channel_hwidth_low_byte};

  assign dly_b = two_stream ? dly_b_prog : dly_a;
  assign wid_b = two_stream ? wid_b_prog : wid_a;

  // Outside two-stream the second link mirrors the first stream's syncs
  assign ev_hs_b = two_stream ? dsi_hsync_b : dsi_hsync_a;
  assign ev_vs_b = two_stream ? dsi_vsync_b : dsi_vsync_a;

  // ============================================================
  // APB answer: one access phase, no wait states
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (hit(paddr, LSD_IDX_MODE))
      next_rdata[7:0] = mode_reg;
    else if (hit(paddr, LSD_IDX_LINK))
      next_rdata[7:0] = link_reg;
    else if (hit(paddr, LSD_IDX_CHA_DLY_LO))
      next_rdata[7:0] = first_channel_delay_low_byte;
    else if (hit(paddr, LSD_IDX_CHA_DLY_HI))
      next_rdata[3:0] = first_channel_delay_high_nibble;
    else if (hit(paddr, LSD_IDX_CHB_DLY_LO))
      next_rdata[7:0] = second_channel_delay_low_byte;
    else if (hit(paddr, LSD_IDX_CHB_DLY_HI))
      next_rdata[3:0] = second_channel_delay_high_nibble;
    else if (hit(paddr, LSD_IDX_CHA_WID_LO))
      next_rdata[7:0] = first_channel_hwidth_low_byte;
    else if (hit(paddr, LSD_IDX_CHA_WID_HI))
      next_rdata[1:0] = first_channel_hwidth_high_bits;
    else if (hit(paddr, LSD_IDX_CHB_WID_LO))
      next_rdata[7:0] = second_channel_hwidth_low_byte;
    else if (hit(paddr, LSD_IDX_CHB_WID_HI))
      next_rdata[1:0] = second_channel_hwidth_high_bits;
    else if (hit(paddr, LSD_IDX_STATUS))
    begin
      next_rdata[0] = lvds_hsync_a;
      next_rdata[1] = lvds_vsync_a;
      next_rdata[2] = lvds_hsync_b;
      next_rdata[3] = lvds_vsync_b;
      next_rdata[LSD_ST_OVF_A_BIT] = ovf_a;
      next_rdata[LSD_ST_OVF_B_BIT] = ovf_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph && !idx_hit;
      if (setup_ph && !pwrite)
        prdata <= next_rdata;
      else if (setup_ph)
        prdata <= 32'h00000000;
    end
  end

  // ============================================================
  // Register writes, taken at the access edge with pready high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= LSD_RST_BYTE;
      link_reg <= LSD_RST_BYTE;
      first_channel_delay_low_byte <= LSD_RST_BYTE;
      first_channel_delay_high_nibble <= LSD_RST_BYTE[3:0];
      second_channel_delay_low_byte <= LSD_RST_BYTE;
      second_channel_delay_high_nibble <= LSD_RST_BYTE[3:0];
    end
    else if (wr_acc)
    begin
      if (hit(paddr, LSD_IDX_MODE))
        mode_reg <= pwdata[7:0];
      if (hit(paddr, LSD_IDX_LINK))
        link_reg <= pwdata[7:0];
      if (hit(paddr, LSD_IDX_CHA_DLY_LO))
        first_channel_delay_low_byte <= pwdata[7:0];
      if (hit(paddr, LSD_IDX_CHA_DLY_HI))
        first_channel_delay_high_nibble <= pwdata[3:0];
      if (hit(paddr, LSD_IDX_CHB_DLY_LO))
        second_channel_delay_low_byte <= pwdata[7:0];
      if (hit(paddr, LSD_IDX_CHB_DLY_HI))
        second_channel_delay_high_nibble <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_channel_hwidth_low_byte <= LSD_RST_BYTE;
      first_channel_hwidth_high_bits <= LSD_RST_BYTE[1:0];
      second_channel_hwidth_low_byte <= LSD_RST_BYTE;
      second_channel_hwidth_high_bits <= LSD_RST_BYTE[1:0];
    end
    else if (wr_acc)
    begin
      if (hit(paddr, LSD_IDX_CHA_WID_LO))
        first_channel_hwidth_low_byte <= pwdata[7:0];
      if (hit(paddr, LSD_IDX_CHA_WID_HI))
        first_channel_hwidth_high_bits <= pwdata[1:0];
      if (hit(paddr, LSD_IDX_CHB_WID_LO))
        second_channel_hwidth_low_byte <= pwdata[7:0];
      if (hit(paddr, LSD_IDX_CHB_WID_HI))
        second_channel_hwidth_high_bits <= pwdata[1:0];
    end
  end

  // Sticky drop flags, write one to clear; a new drop beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_a <= 1'b0;
      ovf_b <= 1'b0;
    end
    else
    begin
      ovf_a <= (ovf_a && !(wr_acc && hit(paddr, LSD_IDX_STATUS) && pwdata[LSD_ST_OVF_A_BIT])) || ch_ovf_a;
      ovf_b <= (ovf_b && !(wr_acc && hit(paddr, LSD_IDX_STATUS) && pwdata[LSD_ST_OVF_B_BIT])) || ch_ovf_b;
    end
  end

  // ============================================================
  // Channels
  lsd_sync_chan u_cha (
    .pclk(pclk),
    .presetn(presetn),
    .hs_in(dsi_hsync_a),
    .vs_in(dsi_vsync_a),
    .delay(dly_a),
    .width(wid_a),
    .hs_out(ch_hs_a),
    .vs_out(ch_vs_a),
    .ovf(ch_ovf_a)
  );

  lsd_sync_chan u_chb (
    .pclk(pclk),
    .presetn(presetn),
    .hs_in(ev_hs_b),
    .vs_in(ev_vs_b),
    .delay(dly_b),
    .width(wid_b),
    .hs_out(ch_hs_b),
    .vs_out(ch_vs_b),
    .ovf(ch_ovf_b)
  );

  // Channel outputs are flip-flops inside each channel
  assign lvds_hsync_a = ch_hs_a;
  assign lvds_vsync_a = ch_vs_a;
  assign lvds_hsync_b = ch_hs_b;
  assign lvds_vsync_b = ch_vs_b;

  // ============================================================
  // Checks
  a_dly_lo_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, LSD_IDX_CHA_DLY_LO)) |=> (dly_a[7:0] == $past(pwdata[7:0])))
    else $error("channel A delay low byte not written");

  a_dly_hi_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, LSD_IDX_CHB_DLY_HI)) |=> (dly_b_prog[11:8] == $past(pwdata[3:0])))
    else $error("channel B delay high nibble not written");

  a_wid_hi_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, LSD_IDX_CHA_WID_HI)) |=> (wid_a[9:8] == $past(pwdata[1:0])))
    else $error("channel A width high bits not written");

  a_shared_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (!single_link && mode_reg[LSD_MODE_LSB+:2] != LSD_MODE_TWO_STREAM) |-> (dly_b == dly_a))
    else $error("channel B delay not following channel A");

  a_split_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (!link_reg[LSD_LINK_SINGLE_BIT] && mode_reg[6:5] == 2'h2) |-> (dly_b == dly_b_prog))
    else $error("channel B delay not used in two-stream mode");

  a_shared_width: assert property (@(posedge pclk) disable iff (!presetn)
    !two_stream |-> (wid_b == wid_a))
    else $error("channel B width not following channel A");

  a_split_width: assert property (@(posedge pclk) disable iff (!presetn)
    two_stream |-> (wid_b == {second_channel_hwidth_high_bits, second_channel_hwidth_low_byte}))
    else $error("channel B width not used in two-stream mode");

  a_vsync_min_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (dsi_vsync_a && $stable(dly_a)) |-> ##1 !lvds_vsync_a [*8])
    else $error("vsync passed through before the fixed latency");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not exactly one access cycle");

  a_dlyb_lo_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, LSD_IDX_CHB_DLY_LO)) |=> (dly_b_prog[7:0] == $past(pwdata[7:0])))
    else $error("channel B delay low byte not written");

  a_dlya_hi_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, LSD_IDX_CHA_DLY_HI)) |=> (dly_a[11:8] == $past(pwdata[3:0])))
    else $error("channel A delay high nibble not written");

  a_wida_lo_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, LSD_IDX_CHA_WID_LO)) |=> (wid_a[7:0] == $past(pwdata[7:0])))
    else $error("channel A width low byte not written");

  a_widb_lo_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, LSD_IDX_CHB_WID_LO)) |=> (wid_b_prog[7:0] == $past(pwdata[7:0])))
    else $error("channel B width low byte not written");

  a_widb_hi_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, LSD_IDX_CHB_WID_HI)) |=> (wid_b_prog[9:8] == $past(pwdata[1:0])))
    else $error("channel B width high bits not written");

  a_single_delay: assert property (@(posedge pclk) disable iff (!presetn)
    single_link |-> (dly_b == dly_a))
    else $error("channel B delay not following channel A in single-link");

  a_single_width: assert property (@(posedge pclk) disable iff (!presetn)
    single_link |-> (wid_b == wid_a))
    else $error("channel B width not following channel A in single-link");

  a_dly_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && hit(paddr, LSD_IDX_CHA_DLY_HI)) |-> (prdata[31:4] == 28'h0000000))
    else $error("delay high register reads nonzero reserved bits");

  a_wid_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && hit(paddr, LSD_IDX_CHB_WID_HI)) |-> (prdata[31:2] == 30'h00000000))
    else $error("width high register reads nonzero reserved bits");

  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("apb error flag raised outside the access cycle");

endmodule : lsd_top

// file: sim/lsd_dsi_src.sv
`timescale 1ns/1ps
// ============================================================
// Upstream video source: sync event lines follow the fire request one cycle later
module lsd_dsi_src
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] fire,
  output logic dsi_hsync_a,
  output logic dsi_vsync_a,
  output logic dsi_hsync_b,
  output logic dsi_vsync_b
);
  // Each line is high for as many cycles as its fire bit; a held bit gives back-to-back events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {dsi_hsync_a, dsi_vsync_a, dsi_hsync_b, dsi_vsync_b} <= 4'h0;
    end
    else
    begin
      {dsi_hsync_a, dsi_vsync_a, dsi_hsync_b, dsi_vsync_b} <= fire;
    end
  end
endmodule : lsd_dsi_src

// file: sim/lsd_top_tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the LVDS sync delay and HSync width block
module lsd_top_tb_top;
  import lsd_pkg::*;
  localparam int TMO = 90000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [LSD_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] fire;
  logic hs_a, vs_a, hs_b, vs_b, e;
  logic lvds_hsync_a, lvds_vsync_a, lvds_hsync_b, lvds_vsync_b;
  logic [11:0] da, db;
  logic [9:0] wa, wb;
  logic [7:0] regs [8] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
  logic [7:0] masks [8] = '{8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h03, 8'hFF, 8'h03};
  // Bit 2 single-link, bits 1:0 channel mode
  logic [2:0] cfg [6] = '{3'b100, 3'b000, 3'b001, 3'b011, 3'b010, 3'b110};
  integer seed = 87818;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;

  lsd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dsi_hsync_a(hs_a), .dsi_vsync_a(vs_a), .dsi_hsync_b(hs_b), .dsi_vsync_b(vs_b),
    .lvds_hsync_a(lvds_hsync_a), .lvds_vsync_a(lvds_vsync_a),
    .lvds_hsync_b(lvds_hsync_b), .lvds_vsync_b(lvds_vsync_b));

  lsd_dsi_src i_src (.pclk(pclk), .presetn(presetn), .fire(fire),
    .dsi_hsync_a(hs_a), .dsi_vsync_a(vs_a), .dsi_hsync_b(hs_b), .dsi_vsync_b(vs_b));

  // ============================================================
  // Checking and closing
  task summarize;
    $display("errors %0d checks %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] pick(input logic ts, input logic [31:0] a, input logic [31:0] b);
    return ts ? b : a;
  endfunction : pick

  // ============================================================
  // APB master; waits for pready without assuming a latency
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr

  task rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask : rdchk

  // ============================================================
  // One sync event; measures rise and fall cycle of every output
  task run_ev(input logic ts);
    logic [31:0] rise [4];
    logic [31:0] fall [4];
    logic [31:0] lim, ebd, ebw;
    logic [3:0] o;
    int k, i;
    ebd = pick(ts, 32'(da), 32'(db));
    ebw = pick(ts, 32'(wa), 32'(wb));
    lim = 32'(da) + 32'(db) + 32'(wa) + 32'(wb) + 32'd12;
    for (i = 0; i < 4; i++)
    begin
      rise[i] = 32'h0;
      fall[i] = 32'h0;
    end
    @(posedge pclk);
    fire <= ts ? 4'hF : 4'hC;
    @(posedge pclk);
    fire <= 4'h0;
    for (k = 1; k <= lim; k++)
    begin
      @(posedge pclk);
      #1;
      o = {lvds_hsync_a, lvds_vsync_a, lvds_hsync_b, lvds_vsync_b};
      for (i = 0; i < 4; i++)
      begin
        if (o[i] === 1'b1 && rise[i] == 0)
          rise[i] = k;
        else if (o[i] !== 1'b1 && rise[i] != 0 && fall[i] == 0)
          fall[i] = k;
      end
    end
    chk(rise[3], 32'(da) + 32'd10);
    chk(fall[3], 32'(da) + 32'(wa) + 32'd10);
    chk(rise[2], 32'(da) + 32'd10);
    chk(fall[2], 32'(da) + 32'd11);
    chk(rise[1], ebd + 32'd10);
    chk(fall[1], ebd + ebw + 32'd10);
    chk(rise[0], ebd + 32'd10);
    chk(fall[0], ebd + 32'd11);
  endtask : run_ev

  // ============================================================
  // Clock, reset, watchdog
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == TMO)
    begin
      fail_count++;
      summarize();
    end
  end

  // ============================================================
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, fire} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdchk(regs[i], 32'h0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      wr(regs[i], 32'hFFFF_FFFF);
      rdchk(regs[i], {24'h0, masks[i]}, 1'b0);
    end
    apb(1'b1, 8'h3F, 32'hFFFF_FFFF, r, e);
    chk({31'h0, e}, 32'h1);
    rdchk(8'h3F, 32'h0, 1'b1);
    for (int c = 0; c < 6; c++)
    begin
      wr(LSD_IDX_LINK, 32'(cfg[c][2]) << LSD_LINK_SINGLE_BIT);
      wr(LSD_IDX_MODE, 32'(cfg[c][1:0]) << LSD_MODE_LSB);
      rdchk(LSD_IDX_LINK, 32'(cfg[c][2]) << LSD_LINK_SINGLE_BIT, 1'b0);
      rdchk(LSD_IDX_MODE, 32'(cfg[c][1:0]) << LSD_MODE_LSB, 1'b0);
      for (int j = 0; j < 3; j++)
      begin
        da = 12'd32 + 12'($unsigned($random(seed)) % 512);
        db = 12'd32 + 12'($unsigned($random(seed)) % 512);
        wa = 10'($unsigned($random(seed)) % 1023) + 10'd1;
        wb = 10'($unsigned($random(seed)) % 1023) + 10'd1;
        if (c == 0 && j == 0)
        begin
          da = 12'd32;
          wa = 10'd1;
        end
        if (c == 1 && j == 0)
        begin
          da = 12'hFFF;
          wa = 10'h3FF;
        end
        if (c == 4 && j == 0)
          db = 12'hFFF;
        wr(LSD_IDX_CHA_DLY_LO, {24'h0, da[7:0]});
        wr(LSD_IDX_CHA_DLY_HI, {28'h0, da[11:8]});
        wr(LSD_IDX_CHB_DLY_LO, {24'h0, db[7:0]});
        wr(LSD_IDX_CHB_DLY_HI, {28'h0, db[11:8]});
        wr(LSD_IDX_CHA_WID_LO, {24'h0, wa[7:0]});
        wr(LSD_IDX_CHA_WID_HI, {30'h0, wa[9:8]});
        wr(LSD_IDX_CHB_WID_LO, {24'h0, wb[7:0]});
        wr(LSD_IDX_CHB_WID_HI, {30'h0, wb[9:8]});
        run_ev(cfg[c][2] == 1'b0 && cfg[c][1:0] == LSD_MODE_TWO_STREAM);
      end
    end
    // Five vsyncs in a row overflow both four-deep queues; B mirrors A here
    rdchk(LSD_IDX_STATUS, 32'h0, 1'b0);
    @(posedge pclk);
    fire <= 4'h4;
    repeat (5) @(posedge pclk);
    fire <= 4'h0;
    repeat (da + 20) @(posedge pclk);
    rdchk(LSD_IDX_STATUS, (32'h1 << LSD_ST_OVF_A_BIT) | (32'h1 << LSD_ST_OVF_B_BIT), 1'b0);
    wr(LSD_IDX_STATUS, 32'h1 << LSD_ST_OVF_A_BIT);
    rdchk(LSD_IDX_STATUS, 32'h1 << LSD_ST_OVF_B_BIT, 1'b0);
    wr(LSD_IDX_STATUS, 32'h1 << LSD_ST_OVF_B_BIT);
    rdchk(LSD_IDX_STATUS, 32'h0, 1'b0);
    summarize();
  end
endmodule : lsd_top_tb_top
